// ==== hdl/prs_sequencer.sv ====
/*
  Program run sequencer with two event inputs and APB registers.
  Assumes event inputs, keys and tick are synchronous to ref_clk and
  that the step engine reports a profile setpoint per position.
*/
// Our own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module prs_sequencer
  import prs_pkg::*;
#(
  parameter int STEPS = 16
)
(
  input wire logic ref_clk, // 200 MHz clock
  input wire logic rst, // synchronous reset, active high
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb write
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic [1:0] event_in, // external event contacts
  input wire logic key_press, // any front-panel key pulse
  input wire logic in_menu, // menu screen shown
  input wire logic [1:0] op_level, // operating level
  input wire logic sec_tick, // one-second tick pulse
  input wire logic step_done_end, // engine finished final step
  input wire logic step_done, // engine finished current step
  input wire logic [15:0] process_measurement, // measured value
  input wire logic [15:0] profile_setpoint, // setpoint at probe_pos
  input wire logic [13:0] mv_change, // manipulated change, 0.1 %FS
  input wire logic mv_sample, // mv_change valid pulse
  output logic [3:0] probe_pos, // position probed for setpoint
  output logic run_active, // program running
  output logic hold_active, // program held
  output logic manual_mode, // manual operation
  output logic [3:0] step_now, // current step
  output logic [1:0] pattern_now, // current pattern
  output logic use_final_sp, // regulate at final step setpoint
  output logic view_return, // request measurement view
  output logic loop_break_flag, // loop break detected
  output logic option_access // option/expansion sets reachable
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [31:0] config_reg;
  logic [2:0] ev_assign [2];
  logic [3:0] step_count;
  logic [7:0] exec_counts;
  logic [13:0] loop_width;
  prs_state_t state;
  logic [6:0] idle_cnt;
  logic [1:0] ev_s1, ev_s2, ev_prev;
  logic [1:0] ev_rise, ev_fall;
  logic sw_run, sw_reset;
  logic start_req, reset_req, adv_req;
  logic [1:0] sel_pat;
  logic scanning;
  logic [1:0] next_pattern;
  logic any_left;
  logic [1:0] first_pattern;
  logic apb_wr, apb_rd, addr_ok;
  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && !penable && !pwrite;
  assign addr_ok = (paddr == OFS_CONFIG) || (paddr == OFS_EVENT) ||
    (paddr == OFS_PROGRAM) || (paddr == OFS_LOOP) ||
    (paddr == OFS_STATUS) || (paddr == OFS_COUNTS) ||
    (paddr == OFS_CMD);
  // ----------------------------------------------------------------
  // apb slave: zero wait states, unmapped address errors
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      config_reg <= CFG_RESET;
      ev_assign[0] <= EV_RUN_RESET;
      ev_assign[1] <= EV_ADVANCE;
      step_count <= STEP_COUNT_RESET;
      exec_counts <= 8'hFF;
      loop_width <= LOOP_WIDTH_RESET;
    end
    else if (apb_wr)
    begin
      case (paddr)
        OFS_CONFIG:
        begin
          // time and ramp unit bits are only stored for the step engine
          config_reg <= pwdata;
          if (pwdata[CFG_IDLE_LSB +: 7] > IDLE_MAX)
            config_reg[CFG_IDLE_LSB +: 7] <= IDLE_MAX;
        end
        OFS_EVENT:
        begin
          ev_assign[0] <= (pwdata[2:0] > EV_SEL1) ? EV_OFF : pwdata[2:0];
          ev_assign[1] <= (pwdata[6:4] > EV_SEL1) ? EV_OFF : pwdata[6:4];
        end
        OFS_PROGRAM: step_count <= pwdata[3:0];
        OFS_COUNTS: exec_counts <= pwdata[7:0];
        OFS_LOOP: loop_width <= (pwdata[13:0] > LOOP_WIDTH_MAX) ?
          LOOP_WIDTH_MAX : pwdata[13:0];
        default: ;
      endcase
    end
  end
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      sw_run <= 1'b0;
      sw_reset <= 1'b0;
    end
    else
    begin
      sw_run <= apb_wr && (paddr == OFS_CMD) && pwdata[0];
      sw_reset <= apb_wr && (paddr == OFS_CMD) && pwdata[1];
    end
  end
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      if (apb_rd)
      begin
        case (paddr)
          OFS_CONFIG: prdata <= config_reg;
          OFS_EVENT: prdata <= {25'h0, ev_assign[1], 1'b0, ev_assign[0]};
          OFS_PROGRAM: prdata <= {28'h0, step_count};
          OFS_LOOP: prdata <= {18'h0, loop_width};
          OFS_COUNTS: prdata <= {24'h0, exec_counts};
          OFS_STATUS: prdata <= {20'h0, loop_break_flag, manual_mode,
            hold_active, run_active, pattern_now, state, step_now};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end
  // ----------------------------------------------------------------
  // event inputs: two-stage sync and edge detect
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      ev_s1 <= 2'b00;
      ev_s2 <= 2'b00;
      ev_prev <= 2'b00;
    end
    else
    begin
      ev_s1 <= event_in;
      ev_s2 <= ev_s1;
      ev_prev <= ev_s2;
    end
  end
  assign ev_rise = ev_s2 & ~ev_prev;
  assign ev_fall = ~ev_s2 & ev_prev;
  always_comb
  begin
    reset_req = sw_reset;
    start_req = sw_run;
    adv_req = 1'b0;
    sel_pat = 2'b00;
    for (int i = 0; i < 2; i++)
    begin
      case (ev_assign[i])
        EV_RUN_RESET:
        begin
          if (ev_rise[i])
            reset_req = 1'b1;
          if (ev_fall[i])
            start_req = 1'b1;
        end
        EV_ADVANCE: if (ev_rise[i]) adv_req = 1'b1;
        EV_SEL0: sel_pat[0] = ev_s2[i];
        EV_SEL1: sel_pat[1] = ev_s2[i];
        default: ;
      endcase
    end
  end
  // level assignments follow the input directly
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      manual_mode <= 1'b0;
      hold_active <= 1'b0;
    end
    else
    begin
      manual_mode <= (ev_assign[0] == EV_AUTO_MANUAL && ev_s2[0]) ||
        (ev_assign[1] == EV_AUTO_MANUAL && ev_s2[1]);
      hold_active <= (ev_assign[0] == EV_HOLD && ev_s2[0]) ||
        (ev_assign[1] == EV_HOLD && ev_s2[1]);
    end
  end
  // ----------------------------------------------------------------
  // run-all pattern chaining
  // ----------------------------------------------------------------
  always_comb
  begin
    next_pattern = pattern_now;
    any_left = 1'b0;
    // run-all opens on the lowest pattern with executions, or on pattern 0 when no pattern has any
    first_pattern = 2'b00;
    for (int j = 3; j >= 0; j--)
    begin
      if (exec_counts[2*j +: 2] != 2'b00)
        first_pattern = 2'(j);
    end
    for (int k = 3; k >= 1; k--)
    begin
      if (({30'h0, pattern_now} + 32'(k)) <= 32'd3 &&
        exec_counts[2*(pattern_now + 2'(k)) +: 2] != 2'b00)
      begin
        next_pattern = pattern_now + 2'(k);
        any_left = 1'b1;
      end
    end
  end
  // ----------------------------------------------------------------
  // program state: start scan, steps, end condition
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      state <= ST_RESET;
      step_now <= 4'h0;
      pattern_now <= 2'b00;
      probe_pos <= 4'h0;
      scanning <= 1'b0;
      run_active <= 1'b0;
    end
    else if (reset_req)
    begin
      state <= ST_RESET;
      run_active <= 1'b0;
      scanning <= 1'b0;
      step_now <= 4'h0;
    end
    else if (start_req && state != ST_RUN)
    begin
      pattern_now <= config_reg[CFG_RUN_ALL] ? first_pattern :
        sel_pat;
      probe_pos <= 4'h0;
      step_now <= 4'h0;
      scanning <= config_reg[CFG_START_MEAS] &&
        !config_reg[CFG_RAMP_MODE];
      state <= ST_RUN;
      run_active <= 1'b1;
    end
    else if (scanning)
    begin
      // one position probed per cycle against the start measurement
      if (profile_setpoint == process_measurement)
      begin
        step_now <= probe_pos;
        scanning <= 1'b0;
      end
      else if (probe_pos == step_count)
      begin
        step_now <= 4'h0;
        scanning <= 1'b0;
      end
      else
        probe_pos <= probe_pos + 4'h1;
    end
    else if (state == ST_RUN && !hold_active)
    begin
      if (step_done_end || (step_done && step_now == step_count))
      begin
        if (config_reg[CFG_RUN_ALL] && any_left)
        begin
          pattern_now <= next_pattern;
          step_now <= 4'h0;
        end
        else
        begin
          state <= config_reg[CFG_END_CONT] ? ST_END_HOLD : ST_RESET;
          run_active <= config_reg[CFG_END_CONT];
        end
      end
      else if (adv_req || step_done)
        step_now <= step_now + 4'h1;
    end
    else if (state == ST_END_HOLD)
      step_now <= step_count;
  end
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      use_final_sp <= 1'b0;
    else
      use_final_sp <= (state == ST_END_HOLD);
  end
  // ----------------------------------------------------------------
  // idle return of display
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      idle_cnt <= 7'd0;
      view_return <= 1'b0;
    end
    else
    begin
      view_return <= 1'b0;
      if (key_press || in_menu || op_level == 2'd3)
        idle_cnt <= 7'd0;
      else if (config_reg[CFG_IDLE_LSB +: 7] == 7'd0)
        idle_cnt <= 7'd0;
      else if (sec_tick)
      begin
        if (idle_cnt + 7'd1 >= config_reg[CFG_IDLE_LSB +: 7])
        begin
          view_return <= 1'b1;
          idle_cnt <= 7'd0;
        end
        else
          idle_cnt <= idle_cnt + 7'd1;
      end
    end
  end
  // ----------------------------------------------------------------
  // loop break and security
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      loop_break_flag <= 1'b0;
      option_access <= 1'b1;
    end
    else
    begin
      if (!config_reg[CFG_LOOP_ASSIGN])
        loop_break_flag <= 1'b0;
      else if (mv_sample)
        loop_break_flag <= (mv_change < loop_width);
      option_access <= (config_reg[CFG_SEC_LSB +: 2] <= SEC_OPEN);
    end
  end
endmodule : prs_sequencer
`default_nettype wire

// ==== pkg/prs_pkg.sv ====
/*
  Constants, types and register map of the program run sequencer.
  Assumes an APB master with 32-bit data and a one-second tick input.
*/
`default_nettype none
package prs_pkg;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_EVENT = 8'h04;
  localparam logic [7:0] OFS_PROGRAM = 8'h08;
  localparam logic [7:0] OFS_LOOP = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_COUNTS = 8'h14;
  localparam logic [7:0] OFS_CMD = 8'h18;
  // ----------------------------------------------------------------
  // config field positions
  // ----------------------------------------------------------------
  localparam int CFG_END_CONT = 0;
  localparam int CFG_TIME_MS = 1;
  localparam int CFG_RAMP_MODE = 2;
  localparam int CFG_RATE_HOUR = 3;
  localparam int CFG_START_MEAS = 4;
  localparam int CFG_RUN_ALL = 5;
  localparam int CFG_LOOP_ASSIGN = 6;
  localparam int CFG_IDLE_LSB = 8;
  localparam int CFG_SEC_LSB = 16;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  // ----------------------------------------------------------------
  // limits and defaults
  // ----------------------------------------------------------------
  localparam logic [6:0] IDLE_MAX = 7'd99;
  localparam logic [13:0] LOOP_WIDTH_MAX = 14'd9999;
  localparam logic [13:0] LOOP_WIDTH_RESET = 14'd2;
  localparam logic [3:0] STEP_COUNT_RESET = 4'hF;
  localparam logic [3:0] STEP_LAST = 4'hF;
  localparam int CLK_HZ = 200_000_000;
  localparam logic [1:0] SEC_OPEN = 2'd1;
  typedef enum logic [2:0]
  {
    EV_OFF = 3'b000,
    EV_RUN_RESET = 3'b001,
    EV_AUTO_MANUAL = 3'b010,
    EV_HOLD = 3'b011,
    EV_ADVANCE = 3'b100,
    EV_SEL0 = 3'b101,
    EV_SEL1 = 3'b110
  } prs_event_t;
  typedef enum logic [1:0]
  {
    ST_RESET = 2'b00,
    ST_RUN = 2'b01,
    ST_END_HOLD = 2'b10
  } prs_state_t;
endpackage : prs_pkg
`default_nettype wire

// ==== testbench/prs_panel_model.sv ====
/*
  Switch contacts and front-panel keys facing the sequencer.
  Assumes the bench sets contact and key levels just after a clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module prs_panel_model
(
  input wire logic ref_clk, // clock
  input wire logic [1:0] contact_cmd, // wanted contact levels
  input wire logic key_cmd, // key held down
  output logic [1:0] event_in, // contact levels to device
  output logic key_press // one pulse per press
);
  logic key_held;
  always_ff @(posedge ref_clk)
  begin
    event_in <= contact_cmd;
    key_held <= key_cmd;
    // a long hold still counts as a single press
    key_press <= key_cmd && !key_held;
  end
endmodule : prs_panel_model
`default_nettype wire

// ==== testbench/prs_sequencer_assertions.sv ====
/*
  Port checker of the program run sequencer.
  Assumes it is bound to prs_sequencer and that settings arrive over APB.
*/
`timescale 1ns/1ps
`default_nettype none
module prs_sequencer_chk
  import prs_pkg::*;
(
  input wire logic ref_clk, // clock
  input wire logic rst, // reset
  input wire logic psel, // apb
  input wire logic penable, // apb
  input wire logic pwrite, // apb
  input wire logic [7:0] paddr, // apb
  input wire logic [31:0] pwdata, // apb
  input wire logic pready, // apb
  input wire logic [1:0] event_in, // contacts
  input wire logic in_menu, // menu shown
  input wire logic step_done_end, // final step done
  input wire logic run_active, // running
  input wire logic hold_active, // held
  input wire logic manual_mode, // manual
  input wire logic [3:0] step_now, // step
  input wire logic use_final_sp, // final setpoint
  input wire logic view_return, // view request
  input wire logic option_access // option sets open
);
  logic [31:0] cfg;
  logic [7:0] evc;
  // ----------------------------------------------------------------
  // shadow of settings written by software
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      cfg <= CFG_RESET;
      evc <= 8'h41;
    end
    else if (psel && penable && pready && pwrite)
    begin
      if (paddr == OFS_CONFIG)
        cfg <= pwdata;
      if (paddr == OFS_EVENT)
        evc <= pwdata[7:0];
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  run_reset_a:
  assert property ($rose(event_in[0]) && evc[2:0] == 3'h1 |-> ##[3:5]
    !run_active) else $error("run input rise did not reset");
  run_start_a:
  assert property ($fell(event_in[0]) && evc[2:0] == 3'h1 && !run_active
    && !cfg[CFG_START_MEAS] |-> ##[3:5] run_active && step_now == 4'h0)
    else $error("run input fall did not start at step 0");
  manual_level_a:
  assert property ((evc[2:0] == 3'h2 && event_in[0]) [*6] |-> manual_mode)
    else $error("manual level not followed");
  hold_level_a:
  assert property ((evc[6:4] == 3'h3 && !event_in[1]) [*6] |->
    !hold_active) else $error("hold not released");
  end_reset_a:
  assert property (step_done_end && run_active && !cfg[CFG_END_CONT] &&
    !cfg[CFG_RUN_ALL] |-> ##[1:3] !run_active && !use_final_sp)
    else $error("program end did not reset");
  end_cont_a:
  assert property (step_done_end && run_active && cfg[CFG_END_CONT] |->
    ##[1:3] use_final_sp) else $error("final setpoint not kept");
  idle_off_a:
  assert property (cfg[14:8] == 7'h00 && $past(cfg[14:8]) == 7'h00 |->
    !view_return) else $error("view return with idle time zero");
  menu_idle_a:
  assert property (in_menu && $past(in_menu) |-> !view_return)
    else $error("view return during menu");
  view_pulse_a:
  assert property (view_return |=> !view_return)
    else $error("view return longer than one cycle");
  sec_gate_a:
  assert property ($stable(cfg[17:16]) |=> option_access ==
    ($past(cfg[17:16]) < 2'h2)) else $error("option access wrong");
  cover property ($rose(run_active));
  cover property (view_return);
  cover property ($rose(use_final_sp));
endmodule : prs_sequencer_chk
bind prs_sequencer prs_sequencer_chk i_prs_sequencer_chk (.ref_clk, .rst,
  .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .event_in, .in_menu,
  .step_done_end, .run_active, .hold_active, .manual_mode, .step_now,
  .use_final_sp, .view_return, .option_access);
`default_nettype wire

// ==== testbench/testbench.sv ====
/*
  Self-checking bench of prs_sequencer with the panel model.
  Assumes a 200 MHz clock; a tick every 20 cycles stands for one second.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import prs_pkg::*;
  logic ref_clk = 0;
  logic rst = 1;
  logic psel = 0, penable = 0, pwrite = 0, in_menu = 0, sec_tick = 0;
  logic step_done_end = 0, mv_sample = 0, key_cmd = 0, vr_seen;
  logic step_done = 0, se;
  logic pready, pslverr, key_press, run_active, hold_active, manual_mode;
  logic use_final_sp, view_return, loop_break_flag, option_access;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [1:0] ev_cmd = 2'h0, event_in, pattern_now;
  logic [1:0] op_level = 2'h0;
  logic [15:0] process_measurement = 16'h0, profile_setpoint;
  logic [13:0] mv_change = 14'h0;
  logic [3:0] probe_pos, step_now;
  int err_total = 0, samples_checked = 0, tc = 0;
  logic [7:0] ra [7] = '{OFS_CONFIG, OFS_EVENT, OFS_PROGRAM, OFS_LOOP,
    OFS_STATUS, OFS_COUNTS, 8'h1C};
  logic [31:0] rv [7] = '{32'h0, 32'h41, 32'hF, 32'h2, 32'h0, 32'hFF, 32'h0};
  // engine stub: setpoint rises by 16 per position
  assign profile_setpoint = {12'h000, probe_pos} * 16'h0010;
  initial
  begin
    forever #2.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    tc <= (tc == 19) ? 0 : tc + 1;
    sec_tick <= (tc == 19);
  end
  prs_sequencer i_prs_sequencer (.ref_clk, .rst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .event_in, .key_press,
    .in_menu, .op_level, .sec_tick, .step_done_end, .step_done,
    .process_measurement, .profile_setpoint, .mv_change, .mv_sample,
    .probe_pos, .run_active, .hold_active, .manual_mode, .step_now,
    .pattern_now, .use_final_sp, .view_return, .loop_break_flag,
    .option_access);
  prs_panel_model i_prs_panel_model (.ref_clk, .contact_cmd(ev_cmd),
    .key_cmd, .event_in, .key_press);
  task end_sim;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error %0t: saw %h want %h", $time, got, exp);
    end
  endtask : chk
  task cyc(input int c);
    repeat (c) @(posedge ref_clk);
  endtask : cyc
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge ref_clk);
      k++;
    end
    while (pready !== 1'b1 && k < 16);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
    if (k >= 16)
    begin
      err_total++;
      end_sim();
    end
  endtask : apb
  task ev(input logic [1:0] v);
    ev_cmd <= v;
    cyc(7);
  endtask : ev
  task fin;
    step_done_end <= 1'b1;
    cyc(1);
    step_done_end <= 1'b0;
    cyc(4);
  endtask : fin
  task idle_watch;
    vr_seen = 1'b0;
    repeat (100)
    begin
      cyc(1);
      if (view_return === 1'b1)
        vr_seen = 1'b1;
    end
  endtask : idle_watch
  initial
  begin
    cyc(8);
    rst <= 1'b0;
    chk(option_access, 32'h1);
    for (int i = 0; i < 7; i++)
    begin
      apb(1'b0, ra[i], 32'h0);
      chk(rd, rv[i]);
      chk(se, 32'(i == 6));
    end
    $display("done: register defaults");
    apb(1'b1, OFS_CMD, 32'h1);
    ev(2'b01);
    chk(run_active, 32'h0);
    ev(2'b00);
    chk({run_active, step_now}, 32'h10);
    ev(2'b10);
    ev(2'b00);
    chk(step_now, 32'h1);
    step_done <= 1'b1;
    cyc(1);
    step_done <= 1'b0;
    cyc(2);
    chk(step_now, 32'h2);
    fin();
    chk({run_active, use_final_sp}, 32'h0);
    apb(1'b1, OFS_CONFIG, 32'h1);
    apb(1'b1, OFS_CMD, 32'h1);
    fin();
    chk(use_final_sp, 32'h1);
    apb(1'b1, OFS_PROGRAM, 32'h7);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk({use_final_sp, rd[5:4]}, 32'h6);
    $display("done: run, advance, end");
    apb(1'b1, OFS_EVENT, 32'h32);
    ev(2'b11);
    chk({manual_mode, hold_active}, 32'h3);
    ev(2'b00);
    chk({manual_mode, hold_active}, 32'h0);
    apb(1'b1, OFS_EVENT, 32'h65);
    for (int p = 0; p < 4; p++)
    begin
      ev(2'(p));
      apb(1'b1, OFS_CMD, 32'h2);
      apb(1'b1, OFS_CMD, 32'h1);
      cyc(1);
      chk(pattern_now, 32'(p));
    end
    apb(1'b1, OFS_EVENT, 32'h0);
    ev(2'b00);
    $display("done: level and select inputs");
    apb(1'b1, OFS_CMD, 32'h2);
    apb(1'b1, OFS_CONFIG, 32'h20);
    apb(1'b1, OFS_COUNTS, 32'h54);
    apb(1'b1, OFS_CMD, 32'h1);
    cyc(1);
    chk(pattern_now, 32'h1);
    fin();
    chk(pattern_now, 32'h2);
    apb(1'b1, OFS_CMD, 32'h2);
    apb(1'b1, OFS_CONFIG, 32'h10);
    process_measurement <= 16'h0030;
    apb(1'b1, OFS_CMD, 32'h1);
    cyc(30);
    chk(step_now, 32'h3);
    apb(1'b1, OFS_CMD, 32'h2);
    process_measurement <= 16'h0035;
    apb(1'b1, OFS_CMD, 32'h1);
    cyc(30);
    chk(step_now, 32'h0);
    apb(1'b1, OFS_CMD, 32'h2);
    apb(1'b1, OFS_CONFIG, 32'h1E);
    process_measurement <= 16'h0030;
    apb(1'b1, OFS_CMD, 32'h1);
    cyc(30);
    chk(step_now, 32'h0);
    apb(1'b0, OFS_CONFIG, 32'h0);
    chk(rd[1], 32'h1);
    chk(rd[3], 32'h1);
    $display("done: run-all and measured start");
    apb(1'b1, OFS_CONFIG, 32'h20000);
    cyc(3);
    chk(option_access, 32'h0);
    apb(1'b1, OFS_CONFIG, 32'h40);
    mv_change <= 14'h1;
    mv_sample <= 1'b1;
    cyc(1);
    mv_sample <= 1'b0;
    cyc(3);
    chk({option_access, loop_break_flag}, 32'h3);
    mv_change <= 14'h2;
    mv_sample <= 1'b1;
    cyc(1);
    mv_sample <= 1'b0;
    cyc(3);
    chk(loop_break_flag, 32'h0);
    apb(1'b1, OFS_CONFIG, 32'h300);
    key_cmd <= 1'b1;
    idle_watch();
    chk(vr_seen, 32'h1);
    in_menu <= 1'b1;
    idle_watch();
    chk(vr_seen, 32'h0);
    in_menu <= 1'b0;
    op_level <= 2'h3;
    idle_watch();
    chk(vr_seen, 32'h0);
    op_level <= 2'h0;
    apb(1'b1, OFS_CONFIG, 32'h0);
    idle_watch();
    chk(vr_seen, 32'h0);
    $display("done: security, loop break, idle");
    rst <= 1'b1;
    cyc(2);
    rst <= 1'b0;
    apb(1'b0, OFS_EVENT, 32'h0);
    chk(rd, 32'h41);
    chk(run_active, 32'h0);
    $display("done: mid-run reset");
    end_sim();
  end
endmodule : testbench
`default_nettype wire
